// ==== hdl/cfg_seq_pkg.sv ====
// Shared constants, types and register layout of the startup sequencer
`default_nettype none
package cfg_seq_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_PHASE = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_PIPE = 1;
  localparam int CTRL_LIVE = 2;
  localparam int CTRL_PORT = 3;
  localparam int CTRL_MONPWR = 5;
  localparam int CTRL_SEC = 6;
  // Phase register fields, four bits each
  localparam int PH_CMPL = 0;
  localparam int PH_TRI = 4;
  localparam int PH_WE = 8;
  localparam int PH_LCK = 12;
  localparam int PH_MAT = 16;
  // Status register fields
  localparam int ST_PHASE = 0;
  localparam int ST_RUN = 3;
  localparam int ST_DONE = 4;
  localparam int ST_TRI_REL = 5;
  localparam int ST_WE = 6;
  localparam int ST_REFUSED = 7;
  localparam int ST_RB = 8;
  localparam int ST_RECONF = 9;
  localparam int ST_LOCKED = 10;
  localparam int ST_MATCHED = 11;
  localparam int ST_FIN = 12;
  // Phase option codes: 0..6 is a phase number
  localparam logic [3:0] OPT_MAXPH = 4'h6;
  localparam logic [3:0] OPT_DONE = 4'h7;
  localparam logic [3:0] OPT_KEEP = 4'h8;
  localparam logic [3:0] OPT_NOWAIT = 4'hf;
  // Reset values of the phase options
  localparam logic [3:0] RST_CMPL = 4'h4;
  localparam logic [3:0] RST_TRI = 4'h5;
  localparam logic [3:0] RST_WE = 4'h6;
  localparam logic [3:0] RST_LCK = OPT_NOWAIT;
  localparam logic [3:0] RST_MAT = OPT_NOWAIT;
  // Phase counter values
  localparam logic [2:0] PHASE_FIRST = 3'h0;
  localparam logic [2:0] PHASE_LAST = 3'h6;
  localparam logic [2:0] PHASE_END = 3'h7;
  localparam logic [2:0] PHASE_STEP = 3'h1;
  // Security levels and port choices
  localparam logic [1:0] SEC_NONE = 2'h0;
  localparam logic [1:0] SEC_L1 = 2'h1;
  localparam logic [1:0] SEC_L2 = 2'h2;
  localparam logic [1:0] PORT_AUTO = 2'h0;
  localparam logic [1:0] PORT_TOP = 2'h1;
  localparam logic [1:0] PORT_BOT = 2'h2;
  // Phase-triggered events
  localparam int N_EVENTS = 3;
  localparam int EV_CMPL = 0;
  localparam int EV_TRI = 1;
  localparam int EV_WE = 2;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_FIN} seq_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic done_flag;
    logic global_tristate;
    logic global_write_enable;
    logic bram_enable;
    logic global_set_reset;
    logic global_high_hold;
    logic readback_enable;
    logic reconfig_enable;
    logic port_top_sel;
    logic port_bottom_sel;
    logic monitor_power_off;
  } startup_out_t;
endpackage
`default_nettype wire

// ==== hdl/phase_hit.sv ====
// Decides whether a phase option has been reached
`timescale 1ns/1ps
`default_nettype none
module phase_hit (
  input wire logic [3:0] option,
  input wire logic [2:0] phase,
  input wire logic active,
  input wire logic done_flag,
  output logic hit
);
  // Phase numbers latch on once passed; Done follows the flag; Keep never fires
  always_comb begin
    if (!active) begin
      hit = 1'b0;
    end else if (option <= cfg_seq_pkg::OPT_MAXPH) begin
      hit = ({1'b0, phase} >= option);
    end else if (option == cfg_seq_pkg::OPT_DONE) begin
      hit = done_flag;
    end else begin
      hit = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/phase_stall.sv ====
// Holds the sequencer at a lock or calibration wait phase
`timescale 1ns/1ps
`default_nettype none
module phase_stall (
  input wire logic [3:0] lock_wait_phase,
  input wire logic [3:0] match_phase,
  input wire logic [2:0] phase,
  input wire logic running,
  input wire logic clocks_locked,
  input wire logic calib_matched,
  output logic stall
);
  logic lock_wait;
  logic match_wait;
  // NoWait, Keep or any code above 6 never stalls
  always_comb begin
    lock_wait = (lock_wait_phase <= cfg_seq_pkg::OPT_MAXPH) && (lock_wait_phase[2:0] == phase);
    match_wait = (match_phase <= cfg_seq_pkg::OPT_MAXPH) && (match_phase[2:0] == phase);
    stall = running && ((lock_wait && !clocks_locked) || (match_wait && !calib_matched));
  end
endmodule
`default_nettype wire

// ==== hdl/config_startup_sequencer.sv ====
// Startup phase sequencer with APB register access
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module config_startup_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire cfg_seq_pkg::apb_req_t apb_req,
  output cfg_seq_pkg::apb_rsp_t apb_rsp,
  input wire logic clocks_locked,
  input wire logic calib_matched,
  output cfg_seq_pkg::startup_out_t startup_out
);

  typedef struct packed {
    cfg_seq_pkg::apb_rsp_t rsp;
    logic pipe_opt;
    logic live_opt;
    logic [1:0] port_choice;
    logic monpwr_opt;
    logic [1:0] sec;
    logic [3:0] cmpl_phase;
    logic [3:0] tri_phase;
    logic [3:0] we_phase;
    logic [3:0] lck_phase;
    logic [3:0] mat_phase;
    cfg_seq_pkg::seq_state_t st;
    logic [2:0] phase;
    logic pipe_stage;
    logic refused;
    cfg_seq_pkg::startup_out_t out;
  } state_t;

  state_t state_q;
  state_t state_d;

  logic [3:0] ev_opt [cfg_seq_pkg::N_EVENTS];
  logic [cfg_seq_pkg::N_EVENTS-1:0] ev_hit;
  logic active;
  logic running;
  logic stall;
  logic acc;
  logic xfer;
  logic wr_ctrl;
  logic start_req;
  logic [31:0] ctrl_word;
  logic [31:0] phase_word;
  logic [31:0] status_word;

  // Outputs come straight from the state register
  assign apb_rsp = state_q.rsp;
  assign startup_out = state_q.out;

  // Sequencer activity
  assign active = (state_q.st != cfg_seq_pkg::SEQ_IDLE);
  assign running = (state_q.st == cfg_seq_pkg::SEQ_RUN);

  // Event options, in event index order
  assign ev_opt[cfg_seq_pkg::EV_CMPL] = state_q.cmpl_phase;
  assign ev_opt[cfg_seq_pkg::EV_TRI] = state_q.tri_phase;
  assign ev_opt[cfg_seq_pkg::EV_WE] = state_q.we_phase;

  // One comparator per phase-triggered event
  genvar gi;
  generate
    for (gi = 0; gi < cfg_seq_pkg::N_EVENTS; gi++) begin : g_ev
      phase_hit u_hit (
        .option(ev_opt[gi]),
        .phase(state_q.phase),
        .active(active),
        .done_flag(state_q.out.done_flag),
        .hit(ev_hit[gi])
      );
    end
  endgenerate

  // Lock and calibration waits; only observes the match, never starts it
  phase_stall u_stall (
    .lock_wait_phase(state_q.lck_phase),
    .match_phase(state_q.mat_phase),
    .phase(state_q.phase),
    .running(running),
    .clocks_locked(clocks_locked),
    .calib_matched(calib_matched),
    .stall(stall)
  );

  // APB phases: acc answers with one wait state, xfer is the committing edge
  assign acc = apb_req.psel && apb_req.penable && !state_q.rsp.pready;
  assign xfer = apb_req.psel && apb_req.penable && state_q.rsp.pready;
  assign wr_ctrl = xfer && apb_req.pwrite && (apb_req.paddr == cfg_seq_pkg::OFF_CTRL);
  assign start_req = wr_ctrl && apb_req.pwdata[cfg_seq_pkg::CTRL_START];

  // Read views of the registers
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[cfg_seq_pkg::CTRL_PIPE] = state_q.pipe_opt;
    ctrl_word[cfg_seq_pkg::CTRL_LIVE] = state_q.live_opt;
    ctrl_word[cfg_seq_pkg::CTRL_PORT +: 2] = state_q.port_choice;
    ctrl_word[cfg_seq_pkg::CTRL_MONPWR] = state_q.monpwr_opt;
    ctrl_word[cfg_seq_pkg::CTRL_SEC +: 2] = state_q.sec;
    phase_word = 32'h0000_0000;
    phase_word[cfg_seq_pkg::PH_CMPL +: 4] = state_q.cmpl_phase;
    phase_word[cfg_seq_pkg::PH_TRI +: 4] = state_q.tri_phase;
    phase_word[cfg_seq_pkg::PH_WE +: 4] = state_q.we_phase;
    phase_word[cfg_seq_pkg::PH_LCK +: 4] = state_q.lck_phase;
    phase_word[cfg_seq_pkg::PH_MAT +: 4] = state_q.mat_phase;
    status_word = 32'h0000_0000;
    status_word[cfg_seq_pkg::ST_PHASE +: 3] = state_q.phase;
    status_word[cfg_seq_pkg::ST_RUN] = running;
    status_word[cfg_seq_pkg::ST_DONE] = state_q.out.done_flag;
    status_word[cfg_seq_pkg::ST_TRI_REL] = !state_q.out.global_tristate;
    status_word[cfg_seq_pkg::ST_WE] = state_q.out.global_write_enable;
    status_word[cfg_seq_pkg::ST_REFUSED] = state_q.refused;
    status_word[cfg_seq_pkg::ST_RB] = state_q.out.readback_enable;
    status_word[cfg_seq_pkg::ST_RECONF] = state_q.out.reconfig_enable;
    status_word[cfg_seq_pkg::ST_LOCKED] = clocks_locked;
    status_word[cfg_seq_pkg::ST_MATCHED] = calib_matched;
    status_word[cfg_seq_pkg::ST_FIN] = (state_q.st == cfg_seq_pkg::SEQ_FIN);
  end

  // Next-state logic for bus, options and startup sequence
  always_comb begin
    state_d = state_q;
    // Bus answer: data and error settle in the wait cycle
    state_d.rsp.pready = acc;
    state_d.rsp.pslverr = 1'b0;
    state_d.rsp.prdata = 32'h0000_0000;
    if (acc) begin
      case (apb_req.paddr)
        cfg_seq_pkg::OFF_CTRL: begin
          state_d.rsp.prdata = ctrl_word;
        end
        cfg_seq_pkg::OFF_PHASE: begin
          state_d.rsp.prdata = phase_word;
        end
        cfg_seq_pkg::OFF_STATUS: begin
          state_d.rsp.pslverr = apb_req.pwrite;
          state_d.rsp.prdata = status_word;
        end
        default: begin
          state_d.rsp.pslverr = 1'b1;
        end
      endcase
      if (apb_req.pwrite) begin
        state_d.rsp.prdata = 32'h0000_0000;
      end
    end

    // Register writes commit only at the edge that sees pready
    if (wr_ctrl) begin
      state_d.pipe_opt = apb_req.pwdata[cfg_seq_pkg::CTRL_PIPE];
      state_d.live_opt = apb_req.pwdata[cfg_seq_pkg::CTRL_LIVE];
      state_d.port_choice = apb_req.pwdata[cfg_seq_pkg::CTRL_PORT +: 2];
      state_d.monpwr_opt = apb_req.pwdata[cfg_seq_pkg::CTRL_MONPWR];
      state_d.sec = apb_req.pwdata[cfg_seq_pkg::CTRL_SEC +: 2];
    end
    // Options are frozen while a sequence runs to avoid torn phase choices
    if (xfer && apb_req.pwrite && apb_req.paddr == cfg_seq_pkg::OFF_PHASE && !running) begin
      state_d.cmpl_phase = apb_req.pwdata[cfg_seq_pkg::PH_CMPL +: 4];
      state_d.tri_phase = apb_req.pwdata[cfg_seq_pkg::PH_TRI +: 4];
      state_d.we_phase = apb_req.pwdata[cfg_seq_pkg::PH_WE +: 4];
      state_d.lck_phase = apb_req.pwdata[cfg_seq_pkg::PH_LCK +: 4];
      state_d.mat_phase = apb_req.pwdata[cfg_seq_pkg::PH_MAT +: 4];
    end

    // Phase stepping
    case (state_q.st)
      cfg_seq_pkg::SEQ_IDLE: begin
        state_d.phase = cfg_seq_pkg::PHASE_FIRST;
      end
      cfg_seq_pkg::SEQ_RUN: begin
        if (!stall) begin
          state_d.phase = state_q.phase + cfg_seq_pkg::PHASE_STEP;
          if (state_q.phase == cfg_seq_pkg::PHASE_LAST) begin
            state_d.st = cfg_seq_pkg::SEQ_FIN;
          end
        end
      end
      cfg_seq_pkg::SEQ_FIN: begin
        state_d.phase = cfg_seq_pkg::PHASE_END;
      end
      default: begin
        state_d.st = cfg_seq_pkg::SEQ_IDLE;
      end
    endcase

    // Start request; a locked-down configuration refuses it while reconfig_enable is low
    if (start_req && !running) begin
      if (state_q.out.reconfig_enable) begin
        state_d.st = cfg_seq_pkg::SEQ_RUN;
        state_d.phase = cfg_seq_pkg::PHASE_FIRST;
        state_d.refused = 1'b0;
      end else begin
        state_d.refused = 1'b1;
      end
    end

    // Completion flag, optionally one stage later
    state_d.pipe_stage = ev_hit[cfg_seq_pkg::EV_CMPL];
    if (state_q.pipe_opt) begin
      state_d.out.done_flag = state_q.pipe_stage && ev_hit[cfg_seq_pkg::EV_CMPL];
    end else begin
      state_d.out.done_flag = ev_hit[cfg_seq_pkg::EV_CMPL];
    end

    // Global controls driven by the reached phases
    state_d.out.global_tristate = !ev_hit[cfg_seq_pkg::EV_TRI];
    state_d.out.global_write_enable = ev_hit[cfg_seq_pkg::EV_WE];
    state_d.out.bram_enable = ev_hit[cfg_seq_pkg::EV_WE];

    // Set/reset and high-hold only during a run, never in live mode
    state_d.out.global_set_reset = running && !state_q.live_opt && !ev_hit[cfg_seq_pkg::EV_WE];
    state_d.out.global_high_hold = running && !state_q.live_opt && !ev_hit[cfg_seq_pkg::EV_TRI];

    // Security gating; level two locks once the device has completed
    state_d.out.readback_enable = (state_q.sec == cfg_seq_pkg::SEC_NONE);
    state_d.out.reconfig_enable = !((state_q.sec == cfg_seq_pkg::SEC_L2) && state_q.out.done_flag);

    // Internal port routing; Auto settles on the top port
    state_d.out.port_top_sel = (state_q.port_choice != cfg_seq_pkg::PORT_BOT);
    state_d.out.port_bottom_sel = (state_q.port_choice == cfg_seq_pkg::PORT_BOT);

    // Monitor power-down is a plain level from its option bit
    state_d.out.monitor_power_off = state_q.monpwr_opt;
  end

  // Single state register; reset puts the fabric in its unconfigured shape
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
      state_q.cmpl_phase <= cfg_seq_pkg::RST_CMPL;
      state_q.tri_phase <= cfg_seq_pkg::RST_TRI;
      state_q.we_phase <= cfg_seq_pkg::RST_WE;
      state_q.lck_phase <= cfg_seq_pkg::RST_LCK;
      state_q.mat_phase <= cfg_seq_pkg::RST_MAT;
      state_q.st <= cfg_seq_pkg::SEQ_IDLE;
      state_q.out.global_tristate <= 1'b1;
      state_q.out.readback_enable <= 1'b1;
      state_q.out.reconfig_enable <= 1'b1;
      state_q.out.port_top_sel <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // Checks on the sequencer behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  done_at_phase_a: assert property (
    (ev_hit[cfg_seq_pkg::EV_CMPL] && !state_q.pipe_opt) |=> startup_out.done_flag)
    else $error("Completion flag missing at its phase");

  done_pipe_a: assert property (
    ($rose(ev_hit[cfg_seq_pkg::EV_CMPL]) && state_q.pipe_opt && $stable(state_q.pipe_opt))
      |=> !startup_out.done_flag ##1 startup_out.done_flag)
    else $error("Pipelined completion flag not one cycle late");

  tristate_release_a: assert property (
    $rose(ev_hit[cfg_seq_pkg::EV_TRI]) |=> !startup_out.global_tristate)
    else $error("Tristate not released at its phase");

  write_enable_a: assert property (
    $rose(ev_hit[cfg_seq_pkg::EV_WE]) |=> (startup_out.global_write_enable && startup_out.bram_enable))
    else $error("Write enable not asserted at its phase");

  bram_block_a: assert property (
    startup_out.bram_enable |-> startup_out.global_write_enable)
    else $error("Block memory open before write enable");

  lock_hold_a: assert property (
    (running && state_q.lck_phase <= cfg_seq_pkg::OPT_MAXPH && state_q.phase == state_q.lck_phase[2:0]
      && !clocks_locked) |=> (state_q.phase == $past(state_q.phase)))
    else $error("Sequencer left lock phase without lock");

  match_hold_a: assert property (
    (running && state_q.mat_phase <= cfg_seq_pkg::OPT_MAXPH && state_q.phase == state_q.mat_phase[2:0]
      && !calib_matched) |=> (state_q.phase == $past(state_q.phase)))
    else $error("Sequencer left match phase without match");

  phase_step_a: assert property (
    (running && !stall && state_q.phase != cfg_seq_pkg::PHASE_LAST)
      |=> (state_q.phase == $past(state_q.phase) + cfg_seq_pkg::PHASE_STEP))
    else $error("Phase did not advance by one");

  readback_lock_a: assert property (
    (state_q.sec != cfg_seq_pkg::SEC_NONE) |=> !startup_out.readback_enable)
    else $error("Readback allowed under security");

  reconfig_lock_a: assert property (
    (start_req && !running && state_q.sec == cfg_seq_pkg::SEC_L2 && !startup_out.reconfig_enable)
      |=> (state_q.refused && !running))
    else $error("Reconfiguration accepted under level two");

  live_quiet_a: assert property (
    state_q.live_opt |=> (!startup_out.global_set_reset && !startup_out.global_high_hold))
    else $error("Set/reset asserted in live reconfiguration");

  port_route_a: assert property (
    (state_q.port_choice == cfg_seq_pkg::PORT_BOT) |=> (startup_out.port_bottom_sel && !startup_out.port_top_sel))
    else $error("Bottom port not selected");

  monitor_off_a: assert property (
    state_q.monpwr_opt |=> startup_out.monitor_power_off)
    else $error("Monitor not powered down");

  bram_shut_a: assert property (
    !ev_hit[cfg_seq_pkg::EV_WE] |=> !startup_out.bram_enable)
    else $error("Block memory opened before its phase");

  level_one_reconf_a: assert property (
    (state_q.sec == cfg_seq_pkg::SEC_L1) |=> startup_out.reconfig_enable)
    else $error("Level one blocked reconfiguration");

  level_two_lock_a: assert property (
    (state_q.sec == cfg_seq_pkg::SEC_L2 && startup_out.done_flag) |=> !startup_out.reconfig_enable)
    else $error("Level two left reconfiguration open");

  start_phase_a: assert property (
    (start_req && !running && startup_out.reconfig_enable)
      |=> (running && state_q.phase == cfg_seq_pkg::PHASE_FIRST))
    else $error("Accepted start did not begin at phase zero");

  // Main scenarios reached
  cov_full_run: cover property (running ##1 (state_q.st == cfg_seq_pkg::SEQ_FIN));
  cov_lock_stall: cover property (stall && !clocks_locked ##1 stall ##1 !stall);
  cov_refused: cover property ($rose(state_q.refused));
  cov_pipe_done: cover property (state_q.pipe_opt && $rose(startup_out.done_flag));

endmodule
`default_nettype wire

// ==== test/cal_lock_model.sv ====
// Model of the clock managers and the impedance calibration beside the sequencer
`timescale 1ns/1ps
`default_nettype none
module cal_lock_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lock_go,
  input wire logic match_go,
  input wire logic [7:0] settle,
  output logic clocks_locked,
  output logic calib_matched
);
  logic [7:0] lock_cnt_q;
  logic [7:0] match_cnt_q;
  // Each process runs from its own trigger, never from the startup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_q <= 8'h00;
      match_cnt_q <= 8'h00;
    end else begin
      lock_cnt_q <= !lock_go ? 8'h00 : (lock_cnt_q == 8'hff) ? lock_cnt_q : lock_cnt_q + 8'h01;
      match_cnt_q <= !match_go ? 8'h00 : (match_cnt_q == 8'hff) ? match_cnt_q : match_cnt_q + 8'h01;
    end
  end
  // Settle count of zero answers at once, larger values answer slowly
  assign clocks_locked = lock_go && (lock_cnt_q >= settle);
  assign calib_matched = match_go && (match_cnt_q >= settle);
endmodule
`default_nettype wire

// ==== test/config_startup_sequencer_test.sv ====
// Self-checking bench for the startup sequencer
`timescale 1ns/1ps
`default_nettype none
module config_startup_sequencer_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  cfg_seq_pkg::apb_req_t req = '0;
  cfg_seq_pkg::apb_rsp_t rsp;
  cfg_seq_pkg::startup_out_t so;
  logic clocks_locked;
  logic calib_matched;
  logic lock_go = 1'b0;
  logic match_go = 1'b0;
  logic [7:0] settle = 8'h00;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic err;
  int kd, kt, kw, kb;
  logic seen_gsr, seen_hh;

  // Clock runs free for the whole startup
  always #25 pclk = ~pclk;

  config_startup_sequencer dut (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(req),
    .apb_rsp(rsp),
    .clocks_locked(clocks_locked),
    .calib_matched(calib_matched),
    .startup_out(so)
  );

  cal_lock_model partner (
    .pclk(pclk),
    .presetn(presetn),
    .lock_go(lock_go),
    .match_go(match_go),
    .settle(settle),
    .clocks_locked(clocks_locked),
    .calib_matched(calib_matched)
  );

  task automatic test_done;
    if (n_mismatch == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Cycle counts are judged against a window; zero means never seen
  task automatic chk_k(input int got, input int lo, input int hi, input string what);
    total_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("mismatch at %0t: %s after %0d cycles", $time, what, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: bus answer missing", $time);
      test_done();
    end else begin
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
    end
  endtask

  // Reset also clears the partner, so every case starts clean
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    lock_go <= 1'b0;
    match_go <= 1'b0;
    settle <= 8'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // Optional start, then record the first cycle of each output event
  task automatic run_seq(input logic [31:0] ctrl, input logic go);
    kd = 0;
    kt = 0;
    kw = 0;
    kb = 0;
    seen_gsr = 1'b0;
    seen_hh = 1'b0;
    if (go) apb(1'b1, cfg_seq_pkg::OFF_CTRL, ctrl | 32'h0000_0001);
    for (int k = 1; k <= 40; k++) begin
      @(posedge pclk);
      if (so.done_flag === 1'b1 && kd == 0) kd = k;
      if (so.global_tristate === 1'b0 && kt == 0) kt = k;
      if (so.global_write_enable === 1'b1 && kw == 0) kw = k;
      if (so.bram_enable === 1'b1 && kb == 0) kb = k;
      seen_gsr |= so.global_set_reset;
      seen_hh |= so.global_high_hold;
    end
  endtask

  // Option code to cycle count: phase p shows p + 2 cycles after start, Done one edge after the flag
  function automatic int exp_k(input logic [3:0] code, input int done_k);
    if (code <= cfg_seq_pkg::OPT_MAXPH) return code + 2;
    if (code == cfg_seq_pkg::OPT_DONE) return (done_k == 0) ? 0 : done_k + 1;
    return 0;
  endfunction

  task automatic reg_case;
    chk(32'(so), 32'h0000_021c, "reset outputs");
    apb(1'b0, cfg_seq_pkg::OFF_PHASE, 32'h0);
    chk(rd, 32'h000f_f654, "option defaults");
    apb(1'b0, 12'h00c, 32'h0);
    chk({rd[30:0], err}, 32'h0000_0001, "unmapped read");
    apb(1'b1, cfg_seq_pkg::OFF_STATUS, 32'hffff_ffff);
    chk(32'(err), 32'h1, "status write");
  endtask

  task automatic phase_case(input logic [3:0] c, input logic [3:0] t, input logic [3:0] w, input logic [31:0] ctrl);
    int ed;
    do_reset();
    apb(1'b1, cfg_seq_pkg::OFF_PHASE, {12'h000, 8'hff, w, t, c});
    run_seq(ctrl, 1'b1);
    ed = (c <= 4'h6) ? c + 2 + ctrl[1] : 0;
    chk_k(kd, ed, ed, "completion flag");
    chk_k(kt, exp_k(t, ed), exp_k(t, ed), "tristate release");
    chk_k(kw, exp_k(w, ed), exp_k(w, ed), "write enable");
    chk_k(kb, kw, kw, "block memory enable");
    chk(32'({seen_gsr, seen_hh}), 32'({2{~ctrl[2]}}), "set/reset and high-hold");
    apb(1'b0, cfg_seq_pkg::OFF_STATUS, 32'h0);
    chk(32'({rd[12], rd[2:0]}), 32'h0000_000f, "finished status");
  endtask

  // Partner held back, so the sequencer must park at the wait phase
  task automatic stall_case(input logic [31:0] ph, input logic [2:0] at, input logic mat);
    do_reset();
    apb(1'b1, cfg_seq_pkg::OFF_PHASE, ph);
    run_seq(32'h0, 1'b1);
    chk_k(kd, 0, 0, "completion while stalled");
    apb(1'b0, cfg_seq_pkg::OFF_STATUS, 32'h0);
    chk(32'({rd[11:10], rd[3:0]}), 32'({2'b00, 1'b1, at}), "stall phase");
    if (mat) match_go <= 1'b1;
    else lock_go <= 1'b1;
    run_seq(32'h0, 1'b0);
    chk_k(kd, 6 - at, 6 - at, "completion after release");
  endtask

  // Calibration started before startup, still settling at the match phase; only the rest is waited out
  task automatic prompt_case;
    do_reset();
    settle <= 8'h0c;
    match_go <= 1'b1;
    apb(1'b1, cfg_seq_pkg::OFF_PHASE, 32'h0002_f654);
    run_seq(32'h0, 1'b1);
    chk_k(kd, 8, 8, "stall only until the earlier match");
  endtask

  task automatic security_case;
    do_reset();
    apb(1'b1, cfg_seq_pkg::OFF_CTRL, 32'h0000_0040);
    repeat (2) @(posedge pclk);
    chk(32'({so.readback_enable, so.reconfig_enable}), 32'h1, "level one");
    run_seq(32'h0000_0040, 1'b1);
    chk_k(kd, 6, 6, "level one start");
    do_reset();
    run_seq(32'h0000_0080, 1'b1);
    chk(32'({so.readback_enable, so.reconfig_enable}), 32'h0, "level two");
    apb(1'b1, cfg_seq_pkg::OFF_CTRL, 32'h0000_0081);
    apb(1'b0, cfg_seq_pkg::OFF_STATUS, 32'h0);
    chk(32'({rd[7], rd[3]}), 32'h2, "restart refused");
  endtask

  task automatic port_case;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, cfg_seq_pkg::OFF_CTRL, {26'h0, i[0], i[1:0], 3'h0});
      repeat (2) @(posedge pclk);
      chk(32'({so.port_top_sel, so.port_bottom_sel, so.monitor_power_off}), 32'({i != 2, i == 2, i[0]}), "port");
    end
  endtask

  // Main sequence; every case except port_case starts from a reset
  initial begin
    do_reset();
    reg_case();
    phase_case(4'h4, 4'h5, 4'h6, 32'h0);
    for (int p = 1; p <= 6; p++) begin
      phase_case(4'(p), 4'(p % 6 + 1), 4'((p + 3) % 6 + 1), 32'h0);
    end
    phase_case(4'h4, 4'h5, 4'h6, 32'h0000_0004);
    phase_case(4'h2, 4'h8, 4'h7, 32'h0000_0002);
    phase_case(4'h8, 4'h3, 4'h8, 32'h0);
    stall_case(32'h000f_3654, 3'h3, 1'b0);
    stall_case(32'h0002_f654, 3'h2, 1'b1);
    prompt_case();
    security_case();
    port_case();
    test_done();
  end
endmodule
`default_nettype wire
